// ### verif/loop_detector_call_timing_bench.sv
// self-checking bench for the loop detector call timing block
`default_nettype none
`include "loop_call_consts.svh"
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin errors++; \
    $display("wrong value at %0t: got %h want %h", $time, a, e); end end
module loop_detector_call_timing_bench
    import loop_call_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic i_clk = 0, i_reset_n = 0, i_awvalid = 0, i_wvalid = 0, i_bready = 0;
    logic i_arvalid = 0, i_rready = 0;
    logic [7:0] i_awaddr = 0, i_araddr = 0;
    logic [31:0] i_wdata = 0, rd, o_rdata;
    logic [3:0] i_wstrb = 4'hf;
    logic [1:0] i_detect = 0, i_loop_fail = 0, green = 0, i_phase_green_n;
    logic [1:0][7:0] i_delta = 0;
    logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_induct_disp, o_delta_disp;
    logic [1:0] o_bresp, o_rresp, o_call, o_osc_en, o_retune;
    integer seed = 32'h0000_ba5c;
    int errors = 0, n_checks = 0, k;
    // 100 ns clock
    always #50 i_clk = ~i_clk;
    // ms counter shortened so that one 0.1 s tick is 1000 cycles
    loop_detector_call_timing #(.MS_CYC(10)) dut (.i_clk, .i_reset_n, .i_awvalid, .o_awready,
        .i_awaddr, .i_wvalid, .o_wready, .i_wdata, .i_wstrb, .o_bvalid, .i_bready, .o_bresp,
        .i_arvalid, .o_arready, .i_araddr, .o_rvalid, .i_rready, .o_rdata, .o_rresp,
        .i_detect, .i_phase_green_n, .i_loop_fail, .i_delta, .o_call, .o_osc_en,
        .o_retune, .o_induct_disp, .o_delta_disp);
    phase_ctrl_model ctrl (.i_clk, .i_green(green), .o_phase_green_n(i_phase_green_n));
    task automatic finish_test();
        if (errors == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // a bus wait that ran out ends the run
    task automatic hang(input int n);
        if (n >= 60) begin
            errors++;
            finish_test();
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge i_clk);
    endtask
    // expected peak word: each channel keeps the change it saw, no larger one since
    function automatic logic [31:0] peak_exp(input logic [31:0] d);
        return {16'h0000, d[15:0]};
    endfunction
    // counts channel 0 reset pulses over c cycles
    task automatic cnt(input int c);
        k = 0;
        repeat (c) begin
            @(posedge i_clk);
            if (o_retune[0] === 1'b1) k++;
        end
    endtask
    // bus write: address and data together, bready held until bvalid
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge i_clk);
        i_awvalid <= 1;
        i_wvalid <= 1;
        i_awaddr <= a;
        i_wdata <= d;
        i_bready <= 1;
        do begin
            @(posedge i_clk);
            if (o_awready) i_awvalid <= 0;
            if (o_wready) i_wvalid <= 0;
            n++;
        end while (o_bvalid !== 1'b1 && n < 60);
        i_bready <= 0;
        hang(n);
        `CHK(o_bresp, 2'h0)
    endtask
    // bus read compared with expected data and response
    task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
        int n = 0;
        @(posedge i_clk);
        i_arvalid <= 1;
        i_araddr <= a;
        i_rready <= 1;
        do begin
            @(posedge i_clk);
            if (o_arready) i_arvalid <= 0;
            n++;
        end while (o_rvalid !== 1'b1 && n < 60);
        i_rready <= 0;
        hang(n);
        `CHK(o_rdata, e)
        `CHK(o_rresp, r)
    endtask
    // main sequence on channel 0, ending with a forced call on channel 1
    initial begin
        cyc(8);
        i_reset_n <= 1;
        cyc(10);
        rdc(8'h00, `CFG_RESET, 2'h0);
        rdc(8'h08, `TIM_RESET, 2'h0);
        rdc(8'h1c, 32'h0000_0000, 2'h2);
        rd = $random(seed);
        wr(8'h0c, rd);
        rdc(8'h0c, rd & `TIM_MASK, 2'h0);
        i_delta <= 16'($random(seed));
        i_detect <= 2'h3;
        wr(8'h00, 32'h0000_0009);
        cyc(5);
        `CHK(o_call[0], 1'b1)
        `CHK(o_osc_en[0], 1'b0)
        wr(8'h00, 32'h0000_000a + 32'($random(seed) & 3));
        cyc(5);
        `CHK(o_call[0], 1'b0)
        `CHK(o_osc_en[0], 1'b0)
        i_detect <= 0;
        wr(8'h00, 32'h0000_0004);
        wr(8'h08, 32'h0000_0001);
        i_detect <= 1;
        cyc(5000);
        `CHK(o_call[0], 1'b0)
        cyc(6500);
        `CHK(o_call[0], 1'b1)
        `CHK(o_osc_en, 2'h3)
        i_detect <= 0;
        cyc(5);
        `CHK(o_call[0], 1'b0)
        i_detect <= 1;
        cyc(2000);
        green <= 1;
        cyc(20);
        `CHK(o_call[0], 1'b1)
        green <= 0;
        i_detect <= 0;
        wr(8'h08, 32'h0000_0500);
        i_detect <= 1;
        cyc(10);
        i_detect <= 0;
        cyc(2000);
        `CHK(o_call[0], 1'b1)
        i_detect <= 1;
        cyc(10);
        i_detect <= 0;
        cyc(3000);
        `CHK(o_call[0], 1'b1)
        cyc(4000);
        `CHK(o_call[0], 1'b0)
        wr(8'h00, 32'h0000_0104);
        wr(8'h08, 32'h0000_0000);
        i_detect <= 1;
        cyc(1000);
        `CHK(o_call[0], 1'b1)
        cyc(500);
        `CHK(o_call[0], 1'b0)
        cnt(20000);
        `CHK(k, 1)
        i_detect <= 0;
        cyc(5000);
        i_detect <= 1;
        cyc(1000);
        `CHK(o_call[0], 1'b1)
        i_detect <= 0;
        wr(8'h00, 32'h0000_0004);
        wr(8'h08, 32'h0001_0000);
        i_detect <= 1;
        cyc(2000);
        i_detect <= 0;
        cnt(100);
        `CHK(k, 0)
        `CHK(o_call[0], 1'b0)
        i_detect <= 1;
        cyc(5000);
        `CHK(o_call[0], 1'b1)
        cnt(8000);
        `CHK(k, 1)
        `CHK(o_call[0], 1'b0)
        i_detect <= 0;
        // phase end reset on: expiry waits, a failed loop blocks the reset
        wr(8'h00, 32'h0000_0204);
        i_detect <= 1;
        i_loop_fail <= 1;
        cnt(12000);
        `CHK(k, 0)
        `CHK(o_call[0], 1'b1)
        green <= 1;
        cyc(20);
        green <= 0;
        cnt(20);
        `CHK(k, 0)
        i_loop_fail <= 0;
        green <= 1;
        cyc(20);
        green <= 0;
        cnt(20);
        `CHK(k, 1)
        `CHK(o_call[0], 1'b0)
        i_detect <= 0;
        // extension gated by phase green
        wr(8'h00, 32'h0000_0404);
        wr(8'h08, 32'h0000_0500);
        i_detect <= 1;
        cyc(10);
        i_detect <= 0;
        cyc(10);
        `CHK(o_call[0], 1'b0)
        green <= 1;
        cyc(20);
        i_detect <= 1;
        cyc(10);
        i_detect <= 0;
        cyc(2000);
        `CHK(o_call[0], 1'b1)
        green <= 0;
        cyc(20);
        `CHK(o_call[0], 1'b0)
        rd = $random(seed);
        i_delta <= rd[15:0];
        wr(8'h10, 32'h0000_0003);
        cyc(3);
        `CHK(o_induct_disp, 1'b1)
        `CHK(o_delta_disp, 1'b1)
        i_delta <= 16'h0000;
        cyc(100);
        rdc(8'h18, peak_exp(rd), 2'h0);
        wr(8'h04, 32'h0000_0009);
        cyc(5);
        `CHK(o_call[1], 1'b1)
        `CHK(o_osc_en[1], 1'b0)
        finish_test();
    end
endmodule
`default_nettype wire

// ### verif/phase_ctrl_model.sv
// traffic controller model that drives the active-low phase green pins
`default_nettype none
module phase_ctrl_model (
    input wire logic i_clk,
    input wire logic [1:0] i_green,
    output logic [1:0] o_phase_green_n
);
    timeunit 1ns;
    timeprecision 1ns;
    // pins stay low for the whole green interval and high otherwise
    always_ff @(posedge i_clk) begin
        o_phase_green_n <= ~i_green;
    end
endmodule
`default_nettype wire

// ### verilog/loop_call_consts.svh
// constants for the loop detector call timing block
// Functional notes
// - forced call: output calls, oscillator off
// - channel off: no call, oscillator off
// - call delay 0..255 s from vehicle entry
// - active phase green aborts delay to zero
// - extension 0..25.5 s after zone clears
// - entry during extension returns to detect
// - presence mode holds call while occupied
// - pulse mode: one 125 ms pulse per entry
// - pulse mode tunes out after 2 s
// - pulse mode resensitizes within 0.5 s
// - max presence 1..999 s or off (the 10-bit max_pres field also takes 1000..1023 s)
// - vacancy before expiry drops call, no reset
// - expiry without phase end reset: reset now
// - expiry with phase end reset: wait state
// - phase end reset needs max presence on
// - loop failure blocks reset at green end
// - display options shared, off after 15 min
// - inductance change peak held 2 s
// - extension gating by phase green option
// - nine sensitivities plus forced and off
`ifndef LOOP_CALL_CONSTS_SVH
`define LOOP_CALL_CONSTS_SVH
`define CLK_PERIOD_NS 100
`define MS_NS 1000000
`define TICK_MS 100
`define SECOND_TICKS 10
`define PULSE_MS 125
`define TUNE_OUT_MS 2000
`define PEAK_HOLD_MS 2000
`define PEAK_HOLD_TICKS (`PEAK_HOLD_MS / `TICK_MS)
`define DISP_TIMEOUT_MIN 15
`define DISP_TIMEOUT_TICKS (`DISP_TIMEOUT_MIN * 60 * 1000 / `TICK_MS)
`define SENS_FORCE 4'h9
`define REG_CFG0 8'h00
`define REG_CFG1 8'h04
`define REG_TIM0 8'h08
`define REG_TIM1 8'h0c
`define REG_DISP 8'h10
`define REG_STAT 8'h14
`define REG_PEAK 8'h18
`define CFG_MASK 32'h0000_077f
`define TIM_MASK 32'h03ff_ffff
`define CFG_RESET 32'h0000_0004
`define TIM_RESET 32'h0000_0000
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// ### verilog/loop_call_pkg.sv
// types for the loop detector call timing block
`default_nettype none
package loop_call_pkg;
    typedef enum logic [2:0] {
        CH_IDLE, CH_DELAY, CH_DETECT, CH_EXT, CH_WAIT, CH_TUNED
    } ch_state_e;
    typedef struct packed {
        logic [20:0] rsvd;
        logic ext_gate;
        logic phase_end_reset;
        logic pulse;
        logic rsvd1;
        logic [2:0] freq;
        logic [3:0] sens;
    } cfg_s;
    typedef struct packed {
        logic [5:0] rsvd;
        logic [9:0] max_pres;
        logic [7:0] ext;
        logic [7:0] delay;
    } tim_s;
endpackage
`default_nettype wire

// ### verilog/loop_detector_call_timing.sv
// two-channel call timing, state logic and register slave
//
// Our own choices: register access over AXI4-Lite and the placing of the registers.
`default_nettype none
`include "loop_call_consts.svh"
module loop_detector_call_timing
    import loop_call_pkg::*;
#(
    parameter int MS_CYC = `MS_NS / `CLK_PERIOD_NS
) (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [7:0] i_awaddr,
    input wire logic i_wvalid,
    output logic o_wready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    output logic o_bvalid,
    input wire logic i_bready,
    output logic [1:0] o_bresp,
    input wire logic i_arvalid,
    output logic o_arready,
    input wire logic [7:0] i_araddr,
    output logic o_rvalid,
    input wire logic i_rready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    input wire logic [1:0] i_detect,
    input wire logic [1:0] i_phase_green_n,
    input wire logic [1:0] i_loop_fail,
    input wire logic [1:0][7:0] i_delta,
    output logic [1:0] o_call,
    output logic [1:0] o_osc_en,
    output logic [1:0] o_retune,
    output logic o_induct_disp,
    output logic o_delta_disp
);
    cfg_s cfg [2];
    tim_s tim [2];
    ch_state_e st [2];
    logic [13:0] cnt [2];
    logic [13:0] mcnt [2];
    logic [11:0] pcnt [2];
    logic [7:0] peak [2];
    logic [4:0] hold [2];
    logic [13:0] ind_cnt;
    logic [13:0] dlt_cnt;
    logic [13:0] ms_cnt;
    logic ms_tick;
    logic [6:0] tk_cnt;
    logic tick;
    logic [1:0] g1;
    logic [1:0] g2;
    logic [1:0] g3;
    logic [1:0] gs;
    logic [1:0] gprev;
    logic [1:0] green;
    logic [1:0] green_fall;
    logic [1:0] normal;
    logic [1:0] eog_eff;
    logic [1:0] in_wait;
    logic aw_have;
    logic w_have;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;

    // byte-lane merge of a write into a stored word, reserved bits masked
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                          input logic [3:0] be, input logic [31:0] m);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                r[8*b +: 8] = d[8*b +: 8];
            end
        end
        return r & m;
    endfunction

    // whole seconds to 0.1 s ticks
    function automatic logic [13:0] secs_to_ticks(input logic [9:0] s);
        return 14'(s) * 14'(`SECOND_TICKS);
    endfunction

    // call level seen by the controller for one channel
    function automatic logic call_of(input ch_state_e s, input cfg_s k, input logic [11:0] p);
        if (k.sens == `SENS_FORCE) begin
            return 1'b1;
        end
        if (k.sens > `SENS_FORCE) begin
            return 1'b0;
        end
        if (s == CH_DETECT) begin
            return k.pulse ? (p < 12'(`PULSE_MS)) : 1'b1;
        end
        return (s == CH_EXT) || (s == CH_WAIT);
    endfunction

    // per-channel decoded conditions
    always_comb begin
        for (int c = 0; c < 2; c++) begin
            normal[c] = cfg[c].sens < `SENS_FORCE;
            eog_eff[c] = cfg[c].phase_end_reset && (tim[c].max_pres != 10'h000);
            in_wait[c] = st[c] == CH_WAIT;
        end
    end
    assign green = ~gs;
    assign green_fall = gprev & ~green;

    // 1 ms prescale and common 0.1 s tick
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            ms_cnt <= 14'h0000;
            ms_tick <= 1'b0;
            tk_cnt <= 7'h00;
            tick <= 1'b0;
        end else begin
            ms_tick <= 1'b0;
            tick <= 1'b0;
            if (ms_cnt == 14'(MS_CYC - 1)) begin
                ms_cnt <= 14'h0000;
                ms_tick <= 1'b1;
            end else begin
                ms_cnt <= ms_cnt + 14'h0001;
            end
            if (ms_tick) begin
                if (tk_cnt == 7'(`TICK_MS - 1)) begin
                    tk_cnt <= 7'h00;
                    tick <= 1'b1;
                end else begin
                    tk_cnt <= tk_cnt + 7'h01;
                end
            end
        end
    end

    // phase green pins: three stages, change taken when stages two and three agree
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            g1 <= 2'h3;
            g2 <= 2'h3;
            g3 <= 2'h3;
            gs <= 2'h3;
            gprev <= 2'h0;
        end else begin
            g1 <= i_phase_green_n;
            g2 <= g1;
            g3 <= g2;
            for (int c = 0; c < 2; c++) begin
                if (g2[c] == g3[c]) begin
                    gs[c] <= g3[c];
                end
            end
            gprev <= green;
        end
    end

    // channel state machines and their timers
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            for (int c = 0; c < 2; c++) begin
                st[c] <= CH_IDLE;
                cnt[c] <= 14'h0000;
                mcnt[c] <= 14'h0000;
                pcnt[c] <= 12'h000;
            end
            o_retune <= 2'h0;
            o_osc_en <= 2'h0;
        end else begin
            for (int c = 0; c < 2; c++) begin
                o_retune[c] <= 1'b0;
                o_osc_en[c] <= normal[c];
                if (!normal[c]) begin
                    st[c] <= CH_IDLE;
                end else begin
                    case (st[c])
                        CH_IDLE: begin
                            if (i_detect[c]) begin
                                mcnt[c] <= secs_to_ticks(tim[c].max_pres);
                                pcnt[c] <= 12'h000;
                                if (green[c] || tim[c].delay == 8'h00) begin
                                    st[c] <= CH_DETECT;
                                end else begin
                                    st[c] <= CH_DELAY;
                                    cnt[c] <= secs_to_ticks(10'(tim[c].delay));
                                end
                            end
                        end
                        CH_DELAY: begin
                            if (!i_detect[c]) begin
                                st[c] <= CH_IDLE;
                            end else if (green[c] || cnt[c] == 14'h0000) begin
                                st[c] <= CH_DETECT;
                                mcnt[c] <= secs_to_ticks(tim[c].max_pres);
                                pcnt[c] <= 12'h000;
                            end else if (tick) begin
                                cnt[c] <= cnt[c] - 14'h0001;
                            end
                        end
                        CH_DETECT: begin
                            if (ms_tick && pcnt[c] < 12'(`TUNE_OUT_MS)) begin
                                pcnt[c] <= pcnt[c] + 12'h001;
                            end
                            if (tick && mcnt[c] != 14'h0000) begin
                                mcnt[c] <= mcnt[c] - 14'h0001;
                            end
                            if (cfg[c].pulse) begin
                                if (!i_detect[c]) begin
                                    st[c] <= CH_IDLE;
                                end else if (pcnt[c] >= 12'(`TUNE_OUT_MS)) begin
                                    st[c] <= CH_TUNED;
                                    o_retune[c] <= 1'b1;
                                end
                            end else if (!i_detect[c]) begin
                                if (tim[c].ext != 8'h00 && (!cfg[c].ext_gate || green[c])) begin
                                    st[c] <= CH_EXT;
                                    cnt[c] <= 14'(tim[c].ext);
                                end else begin
                                    st[c] <= CH_IDLE;
                                end
                            end else if (tim[c].max_pres != 10'h000 && mcnt[c] == 14'h0000) begin
                                if (eog_eff[c]) begin
                                    st[c] <= CH_WAIT;
                                end else begin
                                    st[c] <= CH_TUNED;
                                    o_retune[c] <= 1'b1;
                                end
                            end
                        end
                        CH_EXT: begin
                            if (tick && mcnt[c] != 14'h0000) begin
                                mcnt[c] <= mcnt[c] - 14'h0001;
                            end
                            if (i_detect[c]) begin
                                st[c] <= CH_DETECT;
                            end else if (cnt[c] == 14'h0000 || (cfg[c].ext_gate && !green[c])) begin
                                st[c] <= CH_IDLE;
                            end else if (tick) begin
                                cnt[c] <= cnt[c] - 14'h0001;
                            end
                        end
                        CH_WAIT: begin
                            if (!i_detect[c]) begin
                                st[c] <= CH_IDLE;
                            end else if (green_fall[c] && !i_loop_fail[c]) begin
                                st[c] <= CH_TUNED;
                                o_retune[c] <= 1'b1;
                            end
                        end
                        CH_TUNED: begin
                            if (!i_detect[c]) begin
                                st[c] <= CH_IDLE;
                            end
                        end
                        default: begin
                            st[c] <= CH_IDLE;
                        end
                    endcase
                end
            end
        end
    end

    // call outputs to the controller
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_call <= 2'h0;
        end else begin
            for (int c = 0; c < 2; c++) begin
                o_call[c] <= call_of(st[c], cfg[c], pcnt[c]);
            end
        end
    end

    // peak inductance change held while the change display is on
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            for (int c = 0; c < 2; c++) begin
                peak[c] <= 8'h00;
                hold[c] <= 5'h00;
            end
        end else begin
            for (int c = 0; c < 2; c++) begin
                if (!o_delta_disp) begin
                    peak[c] <= 8'h00;
                    hold[c] <= 5'h00;
                end else if (i_delta[c] > peak[c]) begin
                    peak[c] <= i_delta[c];
                    hold[c] <= 5'h00;
                end else if (tick) begin
                    if (hold[c] == 5'(`PEAK_HOLD_TICKS - 1)) begin
                        peak[c] <= i_delta[c];
                        hold[c] <= 5'h00;
                    end else begin
                        hold[c] <= hold[c] + 5'h01;
                    end
                end
            end
        end
    end

    // write channels, configuration words and display time-outs
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_awready <= 1'b0;
            o_wready <= 1'b0;
            aw_have <= 1'b0;
            w_have <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            o_bvalid <= 1'b0;
            o_bresp <= `RESP_OKAY;
            cfg[0] <= cfg_s'(`CFG_RESET);
            cfg[1] <= cfg_s'(`CFG_RESET);
            tim[0] <= tim_s'(`TIM_RESET);
            tim[1] <= tim_s'(`TIM_RESET);
            o_induct_disp <= 1'b0;
            o_delta_disp <= 1'b0;
            ind_cnt <= 14'h0000;
            dlt_cnt <= 14'h0000;
        end else begin
            o_awready <= i_awvalid && !o_awready && !aw_have && !o_bvalid;
            o_wready <= i_wvalid && !o_wready && !w_have && !o_bvalid;
            if (i_awvalid && o_awready) begin
                aw_have <= 1'b1;
                aw_addr <= i_awaddr;
            end
            if (i_wvalid && o_wready) begin
                w_have <= 1'b1;
                w_data <= i_wdata;
                w_strb <= i_wstrb;
            end
            if (o_bvalid && i_bready) begin
                o_bvalid <= 1'b0;
            end
            if (o_induct_disp && tick) begin
                ind_cnt <= ind_cnt + 14'h0001;
                if (ind_cnt == 14'(`DISP_TIMEOUT_TICKS - 1)) begin
                    o_induct_disp <= 1'b0;
                end
            end
            if (o_delta_disp && tick) begin
                dlt_cnt <= dlt_cnt + 14'h0001;
                if (dlt_cnt == 14'(`DISP_TIMEOUT_TICKS - 1)) begin
                    o_delta_disp <= 1'b0;
                end
            end
            // a write wins over a same-cycle time-out
            if (aw_have && w_have && !o_bvalid) begin
                aw_have <= 1'b0;
                w_have <= 1'b0;
                o_bvalid <= 1'b1;
                o_bresp <= `RESP_OKAY;
                case (aw_addr)
                    `REG_CFG0: cfg[0] <= cfg_s'(merge(cfg[0], w_data, w_strb, `CFG_MASK));
                    `REG_CFG1: cfg[1] <= cfg_s'(merge(cfg[1], w_data, w_strb, `CFG_MASK));
                    `REG_TIM0: tim[0] <= tim_s'(merge(tim[0], w_data, w_strb, `TIM_MASK));
                    `REG_TIM1: tim[1] <= tim_s'(merge(tim[1], w_data, w_strb, `TIM_MASK));
                    `REG_DISP: begin
                        if (w_strb[0]) begin
                            o_induct_disp <= w_data[0];
                            o_delta_disp <= w_data[1];
                            ind_cnt <= 14'h0000;
                            dlt_cnt <= 14'h0000;
                        end
                    end
                    `REG_STAT, `REG_PEAK: begin
                    end
                    default: o_bresp <= `RESP_SLVERR;
                endcase
            end
        end
    end

    // read channel
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_arready <= 1'b0;
            o_rvalid <= 1'b0;
            o_rdata <= 32'h0000_0000;
            o_rresp <= `RESP_OKAY;
        end else begin
            o_arready <= i_arvalid && !o_arready && !o_rvalid;
            if (o_rvalid && i_rready) begin
                o_rvalid <= 1'b0;
            end
            if (i_arvalid && o_arready) begin
                o_rvalid <= 1'b1;
                o_rresp <= `RESP_OKAY;
                case (i_araddr)
                    `REG_CFG0: o_rdata <= cfg[0];
                    `REG_CFG1: o_rdata <= cfg[1];
                    `REG_TIM0: o_rdata <= tim[0];
                    `REG_TIM1: o_rdata <= tim[1];
                    `REG_DISP: o_rdata <= {30'h0000_0000, o_delta_disp, o_induct_disp};
                    `REG_STAT: o_rdata <= {24'h00_0000, green, i_loop_fail, in_wait, o_call};
                    `REG_PEAK: o_rdata <= {16'h0000, peak[1], peak[0]};
                    default: begin
                        o_rdata <= 32'h0000_0000;
                        o_rresp <= `RESP_SLVERR;
                    end
                endcase
            end
        end
    end

    // checks on channel 0 and on the bus
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_reset_n);

    sequence s_wait_fall;
        st[0] == CH_WAIT && green_fall[0] && !i_loop_fail[0] && i_detect[0] && normal[0];
    endsequence
    sequence s_enter_wait;
        st[0] != CH_WAIT ##1 st[0] == CH_WAIT;
    endsequence

    a_forced_call: assert property (cfg[0].sens == `SENS_FORCE |=> o_call[0] && !o_osc_en[0])
        else $error("forced call not held");
    a_channel_off: assert property (cfg[0].sens > `SENS_FORCE |=> !o_call[0] && !o_osc_en[0])
        else $error("disabled channel calls");
    a_green_abort: assert property (normal[0] && st[0] == CH_DELAY && i_detect[0] && green[0]
        |=> st[0] == CH_DETECT) else $error("green did not abort delay");
    a_ext_return: assert property (normal[0] && st[0] == CH_EXT && i_detect[0]
        |=> st[0] == CH_DETECT) else $error("entry during extension ignored");
    a_pulse_width: assert property (normal[0] && cfg[0].pulse && st[0] == CH_DETECT
        |=> o_call[0] == ($past(pcnt[0]) < 12'(`PULSE_MS))) else $error("pulse width wrong");
    a_tune_out: assert property (normal[0] && cfg[0].pulse && st[0] == CH_DETECT && i_detect[0]
        && pcnt[0] >= 12'(`TUNE_OUT_MS) |=> st[0] == CH_TUNED && o_retune[0])
        else $error("long vehicle not tuned out");
    a_pulse_resens: assert property (normal[0] && cfg[0].pulse && st[0] == CH_DETECT
        && !i_detect[0] |=> st[0] == CH_IDLE) else $error("pulse channel not rearmed");
    a_wait_reset: assert property (s_wait_fall |=> st[0] == CH_TUNED && o_retune[0])
        else $error("no reset at end of green");
    a_wait_vacant: assert property (normal[0] && st[0] == CH_WAIT && !i_detect[0]
        |=> st[0] == CH_IDLE && !o_retune[0]) else $error("vacant wait not released");
    a_fail_no_reset: assert property (normal[0] && st[0] == CH_WAIT && i_detect[0]
        && i_loop_fail[0] |=> st[0] == CH_WAIT && !o_retune[0]) else $error("failed loop reset");
    a_wait_needs_max: assert property (s_enter_wait |-> $past(eog_eff[0]))
        else $error("wait without phase end reset");
    a_bresp_hold: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
        else $error("write response dropped");
    a_rdata_hold: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
        else $error("read data changed while stalled");
endmodule
`default_nettype wire
